// File: src/vaca_map.vh
// opcode, field and timing constants for the vector compare/average unit
`ifndef VACA_MAP_VH
`define VACA_MAP_VH
`define VACA_MAJOR_OP 6'hA
`define VACA_MAJOR_MSB 31
`define VACA_MAJOR_LSB 26
`define VACA_RD_MSB 25
`define VACA_RD_LSB 21
`define VACA_RA_MSB 20
`define VACA_RA_LSB 16
`define VACA_RB_MSB 15
`define VACA_RB_LSB 11
`define VACA_MINOR_MSB 7
`define VACA_MINOR_LSB 0
`define VACA_OP_BGT 8'h24
`define VACA_OP_HGT 8'h25
`define VACA_OP_BLE 8'h26
`define VACA_OP_HLE 8'h27
`define VACA_OP_BLT 8'h28
`define VACA_OP_HLT 8'h29
`define VACA_OP_BNE 8'h2A
`define VACA_OP_HNE 8'h2B
`define VACA_OP_BAVG 8'h39
`define VACA_OP_HAVG 8'h3A
`define VACA_FLAG_RST 1'h0
`define VACA_RES_RST 64'h0000000000000000
`define VACA_LATENCY 1
`endif

// File: src/vaca_lanes.v
// per-lane compare and average for one lane width
`timescale 1ns/100ps
module vaca_lanes
#(
  parameter LANE_W = 8,
  parameter DATA_W = 64
)
(
  input wire [DATA_W-1:0] src_a,
  input wire [DATA_W-1:0] src_b,
  output wire [DATA_W/LANE_W-1:0] lane_gt,
  output wire [DATA_W/LANE_W-1:0] lane_lt,
  output wire [DATA_W/LANE_W-1:0] lane_ne,
  output wire [DATA_W-1:0] lane_avg
);
  genvar i;
  generate
    for (i = 0; i < DATA_W/LANE_W; i = i + 1)
    begin : g_lane
      wire [LANE_W-1:0] a_l;
      wire [LANE_W-1:0] b_l;
      wire [LANE_W:0] sum_l;
      assign a_l = src_a[i*LANE_W +: LANE_W];
      assign b_l = src_b[i*LANE_W +: LANE_W];
      // unsigned lanes [RULE14]
      assign lane_gt[i] = a_l > b_l;
      assign lane_lt[i] = a_l < b_l;
      assign lane_ne[i] = a_l != b_l;
      // one extra bit keeps the carry before the shift [RULE14]
      assign sum_l = {1'h0, a_l} + {1'h0, b_l};
      assign lane_avg[i*LANE_W +: LANE_W] = sum_l[LANE_W:1];
    end
  endgenerate
endmodule

// File: src/vaca_unit.v
// vector any-compare and average execution unit
// Contract
// [RULE1] decode major 0xA, register fields, reserved bits, 8-bit minor
// [RULE2] byte any-greater sets flag if some byte of first exceeds second
// [RULE3] any-compare writes the flag into all 64 result bits
// [RULE4] minor 0x25: half-word any-greater
// [RULE5] minor 0x26: byte any-less-or-equal, all eight lanes ORed
// [RULE6] minor 0x27: half-word any-less-or-equal
// [RULE7] minor 0x28: byte any-less-than over all eight lanes
// [RULE8] minor 0x29: half-word any-less-than
// [RULE9] minor 0x2A: byte any-differ
// [RULE10] minor 0x2B: half-word any-differ
// [RULE11] minor 0x39: byte mean, lane sum shifted right one
// [RULE12] minor 0x3A: half-word mean
// [RULE13] half-word mean lanes written to destination
// [RULE14] sums one bit wider; compares unsigned
// [RULE15] no exceptions; 64-bit only
`timescale 1ns/100ps
`include "vaca_map.vh"
module vaca_unit
(
  input wire clk_sys,
  input wire rst_n,
  input wire issue_valid,
  input wire [31:0] insn_word,
  input wire [63:0] first_source_operand,
  input wire [63:0] second_source_operand,
  output reg result_valid_q,
  output reg [63:0] result_q,
  output reg [4:0] dest_reg_q,
  output reg flag_we_q,
  output reg compare_flag_q,
  output wire insn_accept
);
  wire [7:0] b_gt;
  wire [7:0] b_lt;
  wire [7:0] b_ne;
  wire [63:0] b_avg;
  wire [3:0] h_gt;
  wire [3:0] h_lt;
  wire [3:0] h_ne;
  wire [63:0] h_avg;
  wire [5:0] major;
  wire [7:0] minor;
  wire [4:0] dest_field;
  wire major_hit;
  wire any_bgt;
  wire any_hgt;
  wire any_ble;
  wire any_hle;
  wire any_blt;
  wire any_hlt;
  wire any_bne;
  wire any_hne;
  reg hit;
  reg is_cmp;
  reg flag_d;
  reg [63:0] res_d;
  reg valid_d;
  reg flag_we_d;
  reg [4:0] dest_d;
  reg [63:0] result_d;
  reg compare_flag_d;

  vaca_lanes #(.LANE_W(8), .DATA_W(64)) u_byte
  (
    .src_a(first_source_operand),
    .src_b(second_source_operand),
    .lane_gt(b_gt),
    .lane_lt(b_lt),
    .lane_ne(b_ne),
    .lane_avg(b_avg)
  );

  vaca_lanes #(.LANE_W(16), .DATA_W(64)) u_half
  (
    .src_a(first_source_operand),
    .src_b(second_source_operand),
    .lane_gt(h_gt),
    .lane_lt(h_lt),
    .lane_ne(h_ne),
    .lane_avg(h_avg)
  );

  // reserved bits 10:8 are ignored [RULE1]
  assign major = insn_word[`VACA_MAJOR_MSB:`VACA_MAJOR_LSB];
  assign minor = insn_word[`VACA_MINOR_MSB:`VACA_MINOR_LSB];
  assign dest_field = insn_word[`VACA_RD_MSB:`VACA_RD_LSB];
  assign major_hit = (major == `VACA_MAJOR_OP); // [RULE1]
  // the unit never stalls and raises no exception [RULE15]
  assign insn_accept = issue_valid && hit;

  // le is the lane-wise complement of gt, so no separate le lanes
  assign any_bgt = |b_gt; // [RULE2]
  assign any_hgt = |h_gt; // [RULE4]
  assign any_ble = |(~b_gt); // [RULE5]
  assign any_hle = |(~h_gt); // [RULE6]
  assign any_blt = |b_lt; // [RULE7]
  assign any_hlt = |h_lt; // [RULE8]
  assign any_bne = |b_ne; // [RULE9]
  assign any_hne = |h_ne; // [RULE10]

  always @*
  begin
    hit = 1'h0;
    is_cmp = 1'h0;
    flag_d = 1'h0;
    res_d = `VACA_RES_RST;
    if (major_hit)
    begin
      case (minor)
        `VACA_OP_BGT:
        begin
          hit = 1'h1;
          is_cmp = 1'h1;
          flag_d = any_bgt; // [RULE2]
        end
        `VACA_OP_HGT:
        begin
          hit = 1'h1;
          is_cmp = 1'h1;
          flag_d = any_hgt; // [RULE4]
        end
        `VACA_OP_BLE:
        begin
          hit = 1'h1;
          is_cmp = 1'h1;
          flag_d = any_ble; // [RULE5]
        end
        `VACA_OP_HLE:
        begin
          hit = 1'h1;
          is_cmp = 1'h1;
          flag_d = any_hle; // [RULE6]
        end
        `VACA_OP_BLT:
        begin
          hit = 1'h1;
          is_cmp = 1'h1;
          flag_d = any_blt; // [RULE7]
        end
        `VACA_OP_HLT:
        begin
          hit = 1'h1;
          is_cmp = 1'h1;
          flag_d = any_hlt; // [RULE8]
        end
        `VACA_OP_BNE:
        begin
          hit = 1'h1;
          is_cmp = 1'h1;
          flag_d = any_bne; // [RULE9]
        end
        `VACA_OP_HNE:
        begin
          hit = 1'h1;
          is_cmp = 1'h1;
          flag_d = any_hne; // [RULE10]
        end
        `VACA_OP_BAVG:
        begin
          hit = 1'h1;
          res_d = b_avg; // [RULE11]
        end
        `VACA_OP_HAVG:
        begin
          hit = 1'h1;
          res_d = h_avg; // [RULE12] [RULE13]
        end
        default:
        begin
          hit = 1'h0;
        end
      endcase
      if (is_cmp)
        res_d = {64{flag_d}}; // [RULE3]
    end
  end

  // result and destination hold until the next accepted instruction, the flag until the next accepted compare
  always @*
  begin
    valid_d = insn_accept;
    flag_we_d = insn_accept && is_cmp;
    dest_d = dest_reg_q;
    result_d = result_q;
    compare_flag_d = compare_flag_q;
    if (insn_accept)
    begin
      dest_d = dest_field;
      result_d = res_d;
    end
    // mean and foreign instructions leave the flag alone
    if (flag_we_d)
      compare_flag_d = flag_d;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      result_valid_q <= 1'h0;
    else
      result_valid_q <= valid_d;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      flag_we_q <= 1'h0;
    else
      flag_we_q <= flag_we_d;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      dest_reg_q <= 5'h00;
    else
      dest_reg_q <= dest_d;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      result_q <= `VACA_RES_RST;
    else
      result_q <= result_d;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      compare_flag_q <= `VACA_FLAG_RST;
    else
      compare_flag_q <= compare_flag_d;
  end
endmodule

// File: testbench/vaca_unit_asserts.sv
// property checker for the compare/average unit
`timescale 1ns/100ps
module vaca_chk
(
  input clk_sys,
  input rst_n,
  input issue_valid,
  input insn_accept,
  input [31:0] insn_word,
  input [63:0] first_source_operand,
  input [63:0] second_source_operand,
  input result_valid_q,
  input flag_we_q,
  input [63:0] result_q,
  input [4:0] dest_reg_q,
  input compare_flag_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire [7:0] mi = insn_word[7:0];
  wire [5:0] major_f = insn_word[31:26];
  wire [4:0] rd_f = insn_word[25:21];
  reg ne_q;
  reg [8:0] s7_q;
  // nine-bit sum so the lane carry survives the shift
  always @(posedge clk_sys)
  begin
    ne_q <= first_source_operand != second_source_operand;
    s7_q <= first_source_operand[63:56] + {1'h0, second_source_operand[63:56]};
  end
  acc_lat_a: assert property (insn_accept |=> result_valid_q)
    else $error("no result");
  no_acc_a: assert property (!insn_accept |=> !result_valid_q)
    else $error("stray result");
  major_op_a: assert property (insn_accept |-> major_f == 6'hA)
    else $error("bad major");
  dest_field_a: assert property
    (insn_accept |=> dest_reg_q == $past(rd_f))
    else $error("bad dest");
  flag_repl_a: assert property
    (flag_we_q |-> result_q == {64{compare_flag_q}})
    else $error("flag not spread");
  flag_hold_a: assert property
    (!flag_we_q |-> $stable(compare_flag_q))
    else $error("flag moved");
  byte_ne_a: assert property
    (insn_accept && mi == 8'h2A |=> compare_flag_q == ne_q)
    else $error("bad differ");
  mean_top_a: assert property
    (insn_accept && mi == 8'h39 |=> result_q[63:56] == s7_q[8:1])
    else $error("bad mean");
  cover property (flag_we_q && compare_flag_q);
  cover property (result_valid_q && !flag_we_q);
  cover property (issue_valid && !insn_accept);
endmodule
bind vaca_unit vaca_chk vaca_chk_i (.*);

// File: testbench/vaca_core_model.sv
// decode-stage stand-in issuing one instruction at a time
`timescale 1ns/100ps
module vaca_core_model
(
  input clk_sys,
  output reg issue_valid,
  output reg [31:0] insn_word,
  output reg [63:0] first_source_operand,
  output reg [63:0] second_source_operand
);
  initial
  begin
    issue_valid = 1'h0;
    insn_word = 32'h0;
    first_source_operand = 64'h0;
    second_source_operand = 64'h0;
  end
  task send(input [31:0] w, input [63:0] a, input [63:0] b);
  begin
    @(posedge clk_sys) #1;
    issue_valid = 1'h1;
    insn_word = w;
    first_source_operand = a;
    second_source_operand = b;
    @(posedge clk_sys) #1;
    issue_valid = 1'h0;
    // idle operands carry junk, never the last value
    first_source_operand = ~a;
    second_source_operand = ~b;
  end
  endtask
endmodule

// File: testbench/tb.sv
// self-checking bench for the compare/average unit
`timescale 1ns/100ps
module tb;
  reg clk_sys = 1'h0;
  reg rst_n = 1'h0;
  reg fl_exp = 1'h0;
  reg [63:0] r_exp = 64'h0;
  wire iv, acc, rv, fwe, fl;
  wire [31:0] iw;
  wire [63:0] a, b, r;
  wire [4:0] rd;
  integer error_cnt = 0, n_compared = 0, j;
  reg acc_q = 1'h0;
  always #50 clk_sys = ~clk_sys;
  // accept is combinational: sample it at the edge that takes the issue
  always @(posedge clk_sys)
    acc_q <= acc;
  vaca_core_model vaca_core_model_i (.clk_sys(clk_sys), .issue_valid(iv),
    .insn_word(iw), .first_source_operand(a), .second_source_operand(b));
  vaca_unit vaca_unit_i (.clk_sys(clk_sys), .rst_n(rst_n), .issue_valid(iv),
    .insn_word(iw), .first_source_operand(a), .second_source_operand(b),
    .result_valid_q(rv), .result_q(r), .dest_reg_q(rd), .flag_we_q(fwe),
    .compare_flag_q(fl), .insn_accept(acc));
  task stop_test;
  begin
    $display("compared %0d wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  end
  endtask
  function [64:0] ref_op(input [7:0] m, input [63:0] x, input [63:0] y);
    integer k, w;
    reg [16:0] p, q;
    reg f;
    reg [63:0] o;
  begin
    w = (m[0] ^ m[4]) ? 16 : 8;
    f = 1'h0;
    o = 64'h0;
    for (k = 0; k < 64; k = k + w)
    begin
      p = (x >> k) & ((17'h1 << w) - 1);
      q = (y >> k) & ((17'h1 << w) - 1);
      o = o | ({47'h0, p + q} >> 1 << k);
      f = f | (m[3:1] == 3'h2 ? p > q : m[3:1] == 3'h3 ? p <= q
        : m[3:1] == 3'h4 ? p < q : p != q);
    end
    ref_op = m[4] ? {fl_exp, o} : {f, {64{f}}};
  end
  endfunction
  task check(input [72:0] seen, input [72:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value t=%0t got %h want %h", $time, seen, exp);
    end
  end
  endtask
  task run(input [5:0] mj, input [7:0] m, input [63:0] x, input [63:0] y,
    input ok);
    reg [64:0] e;
    reg [72:0] s;
  begin
    vaca_core_model_i.send({mj, 5'h13, 10'h22, 3'h7, m}, x, y);
    e = ok ? ref_op(m, x, y) : {fl_exp, r_exp};
    s = {acc_q, rv, fwe, rd, fl, r};
    check(s, {ok, ok, ok & ~m[4], 5'h13, e});
    {fl_exp, r_exp} = e;
  end
  endtask
  task t_cmp;
  begin
    for (j = 0; j < 32; j = j + 1)
      run(6'hA, 8'h24 + j % 8, j < 8 ? ~64'h0 : j < 16 ? 64'h8000000000000000
        : j < 24 ? 64'h0 : 64'h5A, j < 16 ? 64'h0 : j < 24
        ? 64'h8000000000000000 : 64'h5A, 1'h1);
    $display("compare test done");
  end
  endtask
  task t_mean;
  begin
    run(6'hA, 8'h2A, 64'h1, 64'h0, 1'h1);
    run(6'hA, 8'h39, 64'hFFFF00FF80017FFF, 64'hFFFF01FF80010001, 1'h1);
    run(6'hA, 8'h3A, 64'hFFFF00FF80017FFF, 64'hFFFF01FF80010001, 1'h1);
    $display("mean test done");
  end
  endtask
  task t_refuse;
  begin
    run(6'hB, 8'h25, 64'h1, 64'h0, 1'h0);
    run(6'hA, 8'h23, 64'h1, 64'h0, 1'h0);
    run(6'hA, 8'h3B, 64'h1, 64'h0, 1'h0);
    $display("refuse test done");
  end
  endtask
  task t_reset;
  begin
    @(posedge clk_sys) #1;
    rst_n = 1'h0;
    #1;
    check({acc_q, rv, fwe, rd, fl, r}, 73'h0);
    @(posedge clk_sys) #1;
    rst_n = 1'h1;
    {fl_exp, r_exp} = 65'h0;
    run(6'hA, 8'h26, 64'h5A, 64'h5A, 1'h1);
    $display("reset test done");
  end
  endtask
  initial
  begin
    #100000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'h1;
    t_cmp;
    t_mean;
    t_refuse;
    t_reset;
    stop_test;
  end
endmodule
